// file: design/pdx_pkg.sv
// Package holding constants and types for the paged data-space address extender
package pdx_pkg;
    // Register indices on the plain register port
    localparam logic [3:0]  REG_READ_PAGE   = 4'h0;   // read_page_select
    localparam logic [3:0]  REG_WRITE_PAGE  = 4'h1;   // write_page_select
    localparam logic [3:0]  REG_STATUS      = 4'h2;   // last trap causes, read only
    // Widths
    localparam int          RPAG_W          = 10;
    localparam int          WPAG_W          = 9;
    // Reset values
    localparam logic [9:0]  RPAG_RST        = 10'h001;
    localparam logic [8:0]  WPAG_RST        = 9'h001;
    // Boundary pages
    localparam logic [9:0]  RPAG_EDS_LAST   = 10'h1FF;
    localparam logic [9:0]  RPAG_PS_FIRST   = 10'h200;
    localparam logic [9:0]  RPAG_LSW_LAST   = 10'h2FF;
    localparam logic [9:0]  RPAG_MSB_FIRST  = 10'h300;
    localparam logic [9:0]  RPAG_MSB_LAST   = 10'h3FF;
    localparam logic [9:0]  RPAG_FIRST      = 10'h001;
    localparam logic [8:0]  WPAG_LAST       = 9'h1FF;
    // Address modes of an access
    typedef enum logic [2:0]
    {
        PDX_AM_DIRECT,     // Plain indirect, no modification
        PDX_AM_PREMOD,     // Pre-modified indirect
        PDX_AM_POSTMOD,    // Post-modified indirect
        PDX_AM_REGOFS,     // Register offset
        PDX_AM_MODULO,     // Modulo addressing
        PDX_AM_BITREV      // Bit-reversed addressing
    } pdx_amode_t;
endpackage

// file: design/pdx_page_step.sv
// Page step unit: next page and bit 15 after a page overflow or underflow
`timescale 1ns/100ps
module pdx_page_step #(
    parameter int W = 10
) (
    input  wire logic [W-1:0] page,      // Current page
    input  wire logic         is_read,   // Read page register in use
    input  wire logic         ovf,       // Page overflow seen
    input  wire logic         unf,       // Page underflow seen
    input  wire logic         linear,    // Pre/post-modified mode
    output logic      [W-1:0] nxt_page,  // Page after the step
    output logic              bit15      // Effective address bit 15 after step
);
    logic [9:0] p10;  // Page widened for boundary compares

    // Boundary cases first, then the general linear step
    always_comb
    begin
        p10      = 10'(page);
        nxt_page = page;
        bit15    = 1'b1;
        if (!linear)
        begin
            // Wrap inside the current page
            nxt_page = page;
        end
        else if (ovf)
        begin
            if ((is_read && (p10 == pdx_pkg::RPAG_EDS_LAST || p10 == pdx_pkg::RPAG_MSB_LAST))
                || (!is_read && p10 == 10'(pdx_pkg::WPAG_LAST)))
            begin
                bit15 = 1'b0;
            end
            else
            begin
                // 0x2FF steps to 0x300 naturally
                nxt_page = page + W'(1);
            end
        end
        else if (unf)
        begin
            if (is_read && (p10 == pdx_pkg::RPAG_FIRST || p10 == pdx_pkg::RPAG_PS_FIRST))
            begin
                bit15 = 1'b0;
            end
            else
            begin
                // 0x300 steps back to 0x2FF naturally
                nxt_page = page - W'(1);
            end
        end
    end
endmodule

// file: design/pdx_extender.sv
// Paged data-space address extender, top module
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
module pdx_extender #(
    parameter int RPW = 10,  // Read page width
    parameter int WPW = 9    // Write page width
) (
    input  wire logic              clk,            // 20 MHz system clock
    input  wire logic              nrst,           // Synchronous reset, active low
    input  wire logic [3:0]        reg_addr,       // Register index
    input  wire logic [15:0]       reg_wdata,      // Register write data
    input  wire logic              reg_wr,         // Register write strobe
    input  wire logic              reg_rd,         // Register read strobe
    output logic      [15:0]       reg_rdata,      // Read data, cycle after strobe
    input  wire logic              acc_valid,      // Access to decode this cycle
    input  wire logic              acc_write,      // 1 write, 0 read
    input  wire logic [15:0]       effective_address,  // Unmodified address
    input  wire logic [15:0]       ea_modified,    // Address after modification
    input  wire logic              page_ovf,       // Modification carried past 0xFFFF
    input  wire logic              page_unf,       // Modification fell below 0x8000
    input  wire pdx_pkg::pdx_amode_t amode,        // Address mode
    input  wire logic              via_stack_pointer,  // Uses stack_pointer_reg
    input  wire logic              via_frame_pointer,  // Uses frame_pointer_reg
    input  wire logic              frame_pointer_active, // Frame-pointer mode on
    output logic                   out_valid,      // Formed address valid, pulse
    output logic                   out_write,      // Formed access is a write
    output logic                   out_prog,       // Read goes to program_space
    output logic      [23:0]       out_addr,       // Formed 24-bit address
    output logic      [15:0]       out_ea,         // Effective address written back
    output logic                   addr_trap       // Address error trap, pulse
);
    // All state of the module
    typedef struct packed {
        logic [RPW-1:0] rpag;      // read_page_select
        logic [WPW-1:0] wpag;      // write_page_select
        logic [15:0]    rdata;     // Read data register
        logic           valid;     // Output strobe
        logic           write;     // Output direction
        logic           prog;      // Program-space read
        logic [23:0]    addr;      // Formed address
        logic [15:0]    ea;        // Effective address after step
        logic           trap;      // Trap pulse
        logic           trap_ps;   // Sticky: last trap was PS write
        logic           trap_p0;   // Sticky: a page-zero trap seen since reset, not cleared by a later PS write trap
    } pdx_state_t;

    pdx_state_t st_ff;     // Registered state
    pdx_state_t nxt_st;    // Next state

    logic           paged;        // Access goes through a page
    logic           linear;       // Pre/post-modified mode
    logic [RPW-1:0] act_page;     // Page in use, widened
    logic [RPW-1:0] step_page;    // Page after step
    logic           step_b15;     // Bit 15 after step
    logic [15:0]    ea_fin;       // Final effective address
    logic           bypass;       // Stack or frame pointer access

    // Stack pointer and active frame pointer never see paging
    assign bypass   = via_stack_pointer || (via_frame_pointer && frame_pointer_active);
    // Only the upper half of the unmodified address is paged
    assign paged    = effective_address[15] && !bypass;
    assign linear   = (amode == pdx_pkg::PDX_AM_PREMOD) || (amode == pdx_pkg::PDX_AM_POSTMOD);
    // Independent pages chosen by direction
    assign act_page = acc_write ? RPW'(st_ff.wpag) : st_ff.rpag;

    // Boundary and linear stepping of the active page
    pdx_page_step #(
        .W        (RPW)
    ) u_step (
        .page     (act_page),
        .is_read  (!acc_write),
        .ovf      (page_ovf && paged),
        .unf      (page_unf && paged),
        .linear   (linear),
        .nxt_page (step_page),
        .bit15    (step_b15)
    );

    // Bit 15 forced by the step only when a boundary was crossed
    always_comb
    begin
        ea_fin = ea_modified;
        if (paged && (page_ovf || page_unf))
        begin
            ea_fin = {step_b15, ea_modified[14:0]};
        end
    end

    // Next-state logic: registers, address forming, traps
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.valid = 1'b0;
        nxt_st.trap  = 1'b0;
        // Register reads return data the next cycle only
        nxt_st.rdata = 16'h0000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                pdx_pkg::REG_READ_PAGE:  nxt_st.rdata = 16'(st_ff.rpag);
                pdx_pkg::REG_WRITE_PAGE: nxt_st.rdata = 16'(st_ff.wpag);
                pdx_pkg::REG_STATUS:     nxt_st.rdata = {14'h0000, st_ff.trap_p0, st_ff.trap_ps};
                default:                 nxt_st.rdata = 16'h0000;  // Unmapped reads zero
            endcase
        end
        // A zero write is ignored so page zero is never selected by software
        if (reg_wr && reg_addr == pdx_pkg::REG_READ_PAGE && reg_wdata[RPW-1:0] != '0)
        begin
            nxt_st.rpag = reg_wdata[RPW-1:0];
        end
        if (reg_wr && reg_addr == pdx_pkg::REG_WRITE_PAGE && reg_wdata[WPW-1:0] != '0)
        begin
            nxt_st.wpag = reg_wdata[WPW-1:0];
        end
        // Access decode
        if (acc_valid)
        begin
            nxt_st.valid = 1'b1;
            nxt_st.write = acc_write;
            nxt_st.ea    = ea_fin;
            nxt_st.prog  = 1'b0;
            if (!paged || !ea_fin[15])
            begin
                // Base space, page zero directly
                nxt_st.addr = {8'h00, ea_fin};
            end
            else if (acc_write)
            begin
                // Stepped page shifts the window by 32 KB per page
                nxt_st.addr = {step_page[WPW-1:0], ea_fin[14:0]};
            end
            else
            begin
                nxt_st.prog = step_page[RPW-1];
                nxt_st.addr = {step_page[8:0], ea_fin[14:0]};
            end
            // Page zero through the upper half is illegal
            if (paged && act_page == '0)
            begin
                nxt_st.trap    = 1'b1;
                nxt_st.trap_p0 = 1'b1;
                nxt_st.trap_ps = 1'b0;
            end
            // Write page cannot reach program space
            if (paged && acc_write && act_page[RPW-1])
            begin
                nxt_st.trap    = 1'b1;
                nxt_st.trap_ps = 1'b1;
            end
            // Stepped page replaces the active register
            if (paged && linear && (page_ovf || page_unf))
            begin
                if (acc_write)
                    nxt_st.wpag = step_page[WPW-1:0];
                else
                    nxt_st.rpag = step_page;
            end
        end
    end

    // State register; reset loads both pages with one
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_ff      <= '0;
            st_ff.rpag <= pdx_pkg::RPAG_RST;
            st_ff.wpag <= pdx_pkg::WPAG_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = st_ff.rdata;
    assign out_valid = st_ff.valid;
    assign out_write = st_ff.write;
    assign out_prog  = st_ff.prog;
    assign out_addr  = st_ff.addr;
    assign out_ea    = st_ff.ea;
    assign addr_trap = st_ff.trap;
endmodule

// file: dv/pdx_extender_properties.sv
// Port checker for the paged address extender
`timescale 1ns/100ps
module pdx_extender_properties #(
    parameter int RPW = 10,  // Read page width
    parameter int WPW = 9    // Write page width
) (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic [3:0]          reg_addr,
    input wire logic [15:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [15:0]         reg_rdata,
    input wire logic                acc_valid,
    input wire logic                acc_write,
    input wire logic [15:0]         effective_address,
    input wire logic [15:0]         ea_modified,
    input wire logic                page_ovf,
    input wire logic                page_unf,
    input wire pdx_pkg::pdx_amode_t amode,
    input wire logic                via_stack_pointer,
    input wire logic                via_frame_pointer,
    input wire logic                out_valid,
    input wire logic                out_write,
    input wire logic                out_prog,
    input wire logic [23:0]         out_addr,
    input wire logic [15:0]         out_ea,
    input wire logic                addr_trap
);
    // One clock domain, reset disables all checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Wrapping modes keep the page
    logic wrap_mode;  // Offset, modulo or bit-reversed
    assign wrap_mode = amode inside {pdx_pkg::PDX_AM_REGOFS, pdx_pkg::PDX_AM_MODULO, pdx_pkg::PDX_AM_BITREV};
    a_valid_follows: assert property (acc_valid |=> out_valid)
        else $error("formed address missing after access");
    a_no_spurious: assert property (!acc_valid |=> !out_valid && !addr_trap)
        else $error("output pulse without access");
    a_low_half: assert property (acc_valid && !effective_address[15] && !ea_modified[15]
        |=> out_addr == {8'h00, $past(ea_modified)} && !addr_trap) else $error("low half not page zero");
    a_stack_bypass: assert property (acc_valid && via_stack_pointer |=> out_addr[23:16] == 8'h00 && !out_prog)
        else $error("stack access was paged");
    a_write_data: assert property (acc_valid && acc_write |=> out_write && !out_prog)
        else $error("write reached program space");
    a_wrap_bit: assert property (acc_valid && effective_address[15] && wrap_mode && (page_ovf || page_unf)
        && !via_stack_pointer && !via_frame_pointer |=> out_ea[15]) else $error("wrap lost bit 15");
    a_page_store: assert property ((reg_wr && reg_addr == 4'h0 && reg_wdata[9:0] != 10'h000 && !acc_valid)
        ##1 (reg_rd && reg_addr == 4'h0 && !acc_valid) |=> reg_rdata == {6'h00, $past(reg_wdata[9:0], 2)})
        else $error("read page not stored");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    // Main scenarios reached
    c_ovf: cover property (acc_valid && page_ovf);
    c_unf: cover property (acc_valid && page_unf);
    c_prog: cover property (out_valid && out_prog);
endmodule
bind pdx_extender pdx_extender_properties #(.RPW(RPW), .WPW(WPW)) pdx_chk_inst (.*);

// file: dv/pdx_agu_model.sv
// Address generation model issuing data-space accesses
`timescale 1ns/100ps
module pdx_agu_model (
    input  wire logic          clk,
    output logic               acc_valid,
    output logic               acc_write,
    output logic [15:0]        effective_address,
    output logic [15:0]        ea_modified,
    output logic               page_ovf,
    output logic               page_unf,
    output pdx_pkg::pdx_amode_t amode,
    output logic               via_stack_pointer,
    output logic               via_frame_pointer,
    output logic               frame_pointer_active
);
    logic [16:0] sum;  // Modified address with carry
    // Idle at time zero
    initial
    begin
        {acc_valid, acc_write, page_ovf, page_unf, via_stack_pointer} = 5'h00;
        {via_frame_pointer, frame_pointer_active} = 2'h0;
        {effective_address, ea_modified} = 32'h00000000;
        amode = pdx_pkg::PDX_AM_DIRECT;
    end
    // One access; carry and borrow only count inside the upper half
    task automatic go(input logic w, input logic [15:0] ea, input logic [15:0] d, input pdx_pkg::pdx_amode_t m,
                      input logic sp);
        sum = {1'b0, ea} + {1'b0, d};
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= w;
        effective_address <= ea;
        ea_modified <= sum[15:0];
        page_ovf <= ea[15] & ~d[15] & sum[16];
        page_unf <= ea[15] & d[15] & ~sum[15];
        amode <= m;
        via_stack_pointer <= sp;
        @(posedge clk);
        acc_valid <= 1'b0;
        // Released lines show no stale address
        effective_address <= ~ea;
        ea_modified <= ~sum[15:0];
        #1;
    endtask
endmodule

// file: dv/pdx_extender_tb_top.sv
// Testbench top for the paged address extender
`timescale 1ns/100ps
module pdx_extender_tb_top;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, out_ea, rv, ea;
    logic [23:0] out_addr;
    logic [31:0] seed = 32'h0000AFCA;
    logic [9:0]  rp;
    logic [8:0]  wp;
    logic        acc_valid, acc_write, page_ovf, page_unf, via_stack_pointer, via_frame_pointer;
    logic        frame_pointer_active, out_valid, out_write, out_prog, addr_trap;
    logic [15:0] effective_address, ea_modified;
    pdx_pkg::pdx_amode_t amode;
    int n_mismatch = 0;
    int compares = 0;
    pdx_extender pdx_extender_inst (.*);
    pdx_agu_model pdx_agu_model_inst (.*);
    always #25 clk = ~clk;
    // Repeatable random stream
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Expected address of a plain access
    function automatic logic [23:0] exp_addr(input logic w, input logic [9:0] r, input logic [8:0] p,
                                             input logic [15:0] a);
        if (!a[15])
            return {8'h00, a};
        return w ? {p, a[14:0]} : {r[8:0], a[14:0]};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Stepped access, then resulting bit 15 and page
    task automatic step(input logic w, input logic [9:0] p, input pdx_pkg::pdx_amode_t m, input logic up,
                        input logic sp, input logic [9:0] ep, input logic eb);
        wr({3'h0, w}, {6'h00, p});
        pdx_agu_model_inst.go(w, up ? 16'hFFFE : 16'h8000, up ? 16'h0004 : 16'hFFFC, m, sp);
        chk(24'(out_ea[15]), 24'(eb));
        rd({3'h0, w}, rv);
        chk(24'(rv), 24'(ep));
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard at 20000 cycles, far beyond the expected thousand or so cycles
    initial
    begin
        #1000000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, rv); chk(24'(rv), 24'h000001);
        rd(4'h1, rv); chk(24'(rv), 24'h000001);
        rd(4'hF, rv); chk(24'(rv), 24'h000000);
        wr(4'h0, 16'h0000); rd(4'h0, rv); chk(24'(rv), 24'h000001);
        $display("test registers done");
        // Random pages, independent for read and write
        repeat (150)
        begin
            seed = xs(seed);
            rp = (seed[9:0] == 10'h000) ? 10'h002 : seed[9:0];
            wp = (seed[24:16] == 9'h000) ? 9'h002 : seed[24:16];
            wr(4'h0, {seed[15:10], rp});
            wr(4'h1, {seed[31:25], wp});
            seed = xs(seed);
            ea = seed[15:0];
            pdx_agu_model_inst.go(seed[16], ea, 16'h0000, pdx_pkg::PDX_AM_DIRECT, 1'b0);
            chk(24'(out_prog), 24'(!seed[16] && rp[9] && ea[15]));
            chk(24'(addr_trap), 24'h000000);
            // Program-space reads keep the page's low nine bits as the prefix
            chk(out_addr, exp_addr(seed[16], rp, wp, ea));
        end
        $display("test random paging done");
        step(1'b0, 10'h005, pdx_pkg::PDX_AM_POSTMOD, 1'b1, 1'b0, 10'h006, 1'b1);
        step(1'b1, 10'h005, pdx_pkg::PDX_AM_PREMOD, 1'b1, 1'b0, 10'h006, 1'b1);
        step(1'b0, 10'h006, pdx_pkg::PDX_AM_PREMOD, 1'b0, 1'b0, 10'h005, 1'b1);
        step(1'b0, 10'h1FF, pdx_pkg::PDX_AM_POSTMOD, 1'b1, 1'b0, 10'h1FF, 1'b0);
        step(1'b0, 10'h3FF, pdx_pkg::PDX_AM_PREMOD, 1'b1, 1'b0, 10'h3FF, 1'b0);
        step(1'b1, 10'h1FF, pdx_pkg::PDX_AM_POSTMOD, 1'b1, 1'b0, 10'h1FF, 1'b0);
        step(1'b0, 10'h001, pdx_pkg::PDX_AM_POSTMOD, 1'b0, 1'b0, 10'h001, 1'b0);
        step(1'b0, 10'h200, pdx_pkg::PDX_AM_PREMOD, 1'b0, 1'b0, 10'h200, 1'b0);
        step(1'b0, 10'h2FF, pdx_pkg::PDX_AM_POSTMOD, 1'b1, 1'b0, 10'h300, 1'b1);
        step(1'b0, 10'h300, pdx_pkg::PDX_AM_PREMOD, 1'b0, 1'b0, 10'h2FF, 1'b1);
        step(1'b0, 10'h005, pdx_pkg::PDX_AM_REGOFS, 1'b1, 1'b0, 10'h005, 1'b1);
        step(1'b1, 10'h005, pdx_pkg::PDX_AM_MODULO, 1'b0, 1'b0, 10'h005, 1'b1);
        step(1'b0, 10'h005, pdx_pkg::PDX_AM_BITREV, 1'b1, 1'b0, 10'h005, 1'b1);
        step(1'b0, 10'h005, pdx_pkg::PDX_AM_POSTMOD, 1'b1, 1'b1, 10'h005, 1'b0);
        $display("test page stepping done");
        complete_run();
    end
endmodule
